// ===== design/dsc_pkg.sv
`default_nettype none
package dsc_pkg;
    // Scan chain numbers as selected by the test port
    localparam logic [4:0] DSC_CHAIN_ICTAG = 5'h04;
    localparam logic [4:0] DSC_CHAIN_DCTAG = 5'h05;
    localparam logic [4:0] DSC_CHAIN_SCC = 5'h0F;
    // Coprocessor frame layout
    localparam int DSC_SCC_LEN = 39;
    localparam int DSC_SCC_RW_BIT = 38;
    localparam int DSC_SCC_AHI_BIT = 37;
    localparam int DSC_SCC_SIDE_BIT = 32;
    // Tag frame layout
    localparam int DSC_TAG_LEN = 29;
    localparam int DSC_TAG_VALID_BIT = 28;
    localparam int DSC_TAG_DIRTY_BIT = 27;
    localparam int DSC_TAG_W = 27;
    localparam int DSC_IDX_W = 7;
    localparam int DSC_SEG_W = 6;
    // Register numbers in address bits 36:33
    localparam logic [3:0] DSC_REG_FLUSH = 4'h7;
    // Status bit of flush pseudo register
    localparam int DSC_FLUSH_BIT = 31;
    // Reset value of stored words
    localparam logic [31:0] DSC_WORD_RST = 32'h0000_0000;
    // Number of coprocessor register slots (6-bit address space)
    localparam int DSC_NREG = 64;

    // Decoded coprocessor access request
    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [31:0] data;
    } dsc_scc_req_s;

    // Tag entry address as carried to the cache
    typedef struct packed {
        logic [DSC_IDX_W-1:0] index;
        logic [DSC_SEG_W-1:0] segment;
    } dsc_tag_addr_s;

    // Tag entry contents as returned by the cache
    typedef struct packed {
        logic valid;
        logic dirty;
        logic [DSC_TAG_W-1:0] tag;
    } dsc_tag_entry_s;

    // TAP controller states that matter here
    typedef enum logic [3:0] {
        DSC_ST_IDLE = 4'b0001,
        DSC_ST_CAPTURE = 4'b0010,
        DSC_ST_SHIFT = 4'b0100,
        DSC_ST_UPDATE = 4'b1000
    } dsc_tap_e;
endpackage : dsc_pkg
`default_nettype wire

// ===== design/dsc_sync.sv
`default_nettype none
// Three-stage synchroniser; output is the agreed level of stages 2 and 3
module dsc_sync
    import dsc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Asynchronous level in, filtered level out
    input wire logic async_i,
    output logic level_o
);
    logic s1; // First stage, read only by s2
    logic s2;
    logic s3;

    // Shift chain; level moves only when stages 2 and 3 agree
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level_o <= s3;
        end
    end
endmodule : dsc_sync
`default_nettype wire

// ===== design/dsc_top.sv
`default_nettype none
module dsc_top
    import dsc_pkg::*;
(
    // Core clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Test port pins, asynchronous to mclk_i
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic shift_dr_i,
    input wire logic capture_dr_i,
    input wire logic update_dr_i,
    input wire logic [4:0] chain_sel_i,
    output logic tdo_o,
    // Core side status
    input wire logic debug_state_i,
    input wire logic cache_enable_i,
    // Instruction cache flush handshake
    output logic instr_flush_req_o,
    input wire logic instr_flush_done_i,
    // Tag array access
    output logic tag_rd_o,
    output logic tag_rd_data_o,
    output dsc_tag_addr_s tag_addr_o,
    input wire dsc_tag_entry_s tag_entry_i,
    input wire logic tag_ack_i,
    // Uncached load route marker for memory system
    output logic ext_mem_sel_o
);
    logic tck_s, tdi_s, shdr_s, capdr_s, upddr_s;
    logic tck_q; // Previous synchronised clock level
    logic tck_rise;
    logic [DSC_SCC_LEN-1:0] shreg; // Shared shift register
    logic [31:0] regs [DSC_NREG]; // Coprocessor register store
    logic flush_pending;
    logic tag_wait;
    dsc_tap_e tap_st;
    dsc_scc_req_s req;

    // Test port pins other than chain_sel_i pass four flops each
    dsc_sync u_tck (.mclk_i(mclk_i), .nrst_i(nrst_i), .async_i(tck_i),
        .level_o(tck_s));
    dsc_sync u_tdi (.mclk_i(mclk_i), .nrst_i(nrst_i), .async_i(tdi_i),
        .level_o(tdi_s));
    dsc_sync u_sh (.mclk_i(mclk_i), .nrst_i(nrst_i), .async_i(shift_dr_i),
        .level_o(shdr_s));
    dsc_sync u_cap (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .async_i(capture_dr_i), .level_o(capdr_s));
    dsc_sync u_upd (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .async_i(update_dr_i), .level_o(upddr_s));

    // Is this 6-bit address a mapped register slot?
    function automatic logic mapped(input logic [5:0] a);
        if (a[5])
            mapped = 1'b1;
        else
            unique case (a[4:1])
                4'h0, 4'h1, 4'h3, 4'hF: mapped = !a[0];
                4'h2, 4'h5, 4'h9: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
    endfunction : mapped

    // Flush pseudo register address, instruction side
    function automatic logic is_flush(input logic [5:0] a);
        is_flush = !a[5] && a[4:1] == DSC_REG_FLUSH && a[0];
    endfunction : is_flush

    assign tck_rise = tck_s && !tck_q;
    assign req.write = shreg[DSC_SCC_RW_BIT];
    assign req.addr = shreg[DSC_SCC_AHI_BIT:DSC_SCC_SIDE_BIT];
    assign req.data = shreg[31:0];

    // Edge finder on the sampled test clock
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            tck_q <= 1'b0;
        else
            tck_q <= tck_s;
    end

    // Coarse phase tracker, mainly for observation
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            tap_st <= DSC_ST_IDLE;
        else if (tck_rise)
        begin
            if (capdr_s)
                tap_st <= DSC_ST_CAPTURE;
            else if (shdr_s)
                tap_st <= DSC_ST_SHIFT;
            else if (upddr_s)
                tap_st <= DSC_ST_UPDATE;
            else
                tap_st <= DSC_ST_IDLE;
        end
    end

    // Capture, shift, and tag-entry load share one register
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            shreg <= '0;
        else if (tag_wait && tag_ack_i)
        begin
            // Reading format replaces the address frame
            shreg <= '0;
            shreg[DSC_TAG_VALID_BIT] <= tag_entry_i.valid;
            shreg[DSC_TAG_DIRTY_BIT] <= tag_rd_data_o
                && tag_entry_i.dirty;
            shreg[DSC_TAG_W-1:0] <= tag_entry_i.tag;
        end
        else if (tck_rise && capdr_s && chain_sel_i == DSC_CHAIN_SCC)
        begin
            // Reads return the addressed word; unmapped gives zero
            if (!shreg[DSC_SCC_RW_BIT])
            begin
                if (is_flush(req.addr))
                    shreg[31:0] <= {flush_pending, 31'h0};
                else if (mapped(req.addr))
                    shreg[31:0] <= regs[req.addr];
                else
                    shreg[31:0] <= 32'h0000_0000;
            end
        end
        else if (tck_rise && shdr_s)
        begin
            // Shift toward bit 0; tag chains are 29 bits long
            if (chain_sel_i == DSC_CHAIN_SCC)
                shreg <= {tdi_s, shreg[DSC_SCC_LEN-1:1]};
            else
                shreg <= {10'h000, tdi_s,
                    shreg[DSC_TAG_LEN-1:1]};
        end
    end

    // Register writes on update of a write frame
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            for (int i = 0; i < DSC_NREG; i++)
                regs[i] <= DSC_WORD_RST;
        else if (tck_rise && upddr_s && chain_sel_i == DSC_CHAIN_SCC
                 && debug_state_i && req.write
                 && mapped(req.addr) && !is_flush(req.addr))
            regs[req.addr] <= req.data;
    end

    // Flush request: set by write, held until the cache reports done
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            flush_pending <= 1'b0;
        else if (tck_rise && upddr_s && chain_sel_i == DSC_CHAIN_SCC
                 && debug_state_i && req.write && is_flush(req.addr))
            flush_pending <= 1'b1;
        else if (instr_flush_done_i)
            flush_pending <= 1'b0;
    end

    // Tag read request after an addressing scan on chain 4 or 5
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            tag_wait <= 1'b0;
            tag_rd_o <= 1'b0;
            tag_rd_data_o <= 1'b0;
            tag_addr_o <= '0;
        end
        else if (tck_rise && upddr_s && debug_state_i && !tag_wait
                 && (chain_sel_i == DSC_CHAIN_ICTAG
                     || chain_sel_i == DSC_CHAIN_DCTAG))
        begin
            tag_wait <= 1'b1;
            tag_rd_o <= 1'b1;
            tag_rd_data_o <= chain_sel_i == DSC_CHAIN_DCTAG;
            tag_addr_o.index <= shreg[28:22];
            tag_addr_o.segment <= shreg[5:0];
        end
        else
        begin
            tag_rd_o <= 1'b0;
            if (tag_ack_i)
                tag_wait <= 1'b0;
        end
    end

    // Outputs from flops
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            tdo_o <= 1'b0;
            instr_flush_req_o <= 1'b0;
            ext_mem_sel_o <= 1'b0;
        end
        else
        begin
            tdo_o <= shreg[0];
            instr_flush_req_o <= flush_pending;
            ext_mem_sel_o <= !cache_enable_i;
        end
    end

    // Checks
    a_flush_set: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (tck_rise && upddr_s && chain_sel_i == DSC_CHAIN_SCC && debug_state_i
         && req.write && is_flush(req.addr)) |=> flush_pending)
        else $error("flush not started");
    a_flush_req: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        flush_pending |=> instr_flush_req_o)
        else $error("flush request not shown");
    a_flush_clear: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (instr_flush_done_i && !(tck_rise && upddr_s)) |=> !flush_pending)
        else $error("flush not cleared");
    a_ictag_dirty: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (tag_wait && tag_ack_i && !tag_rd_data_o)
        |=> !shreg[DSC_TAG_DIRTY_BIT])
        else $error("instruction tag dirty nonzero");
    a_tag_valid: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (tag_wait && tag_ack_i) |=>
        shreg[DSC_TAG_VALID_BIT] == $past(tag_entry_i.valid))
        else $error("valid bit wrong");
    a_tag_index: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        tag_rd_o |-> tag_addr_o.index == $past(shreg[28:22]))
        else $error("tag index wrong");
    a_tag_chain: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        $rose(tag_rd_o) |-> $past(chain_sel_i == DSC_CHAIN_ICTAG
        || chain_sel_i == DSC_CHAIN_DCTAG))
        else $error("tag read from wrong chain");
    a_unmapped_zero: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        (tck_rise && capdr_s && chain_sel_i == DSC_CHAIN_SCC
         && !tag_wait && !shreg[38] && !mapped(req.addr)
         && !is_flush(req.addr)) |=> shreg[31:0] == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_ext_mem: assert property (
        @(posedge mclk_i) disable iff (!nrst_i)
        !cache_enable_i |=> ext_mem_sel_o)
        else $error("external memory not selected");
    // Flush lasts far longer than a bounded window, so watch its end
    c_flush: cover property (@(posedge mclk_i) $fell(flush_pending));
    c_tap_update: cover property (@(posedge mclk_i)
        tap_st == DSC_ST_UPDATE);
    c_tag_read: cover property (@(posedge mclk_i) tag_wait && tag_ack_i);
    c_write: cover property (@(posedge mclk_i) tck_rise && upddr_s
        && req.write && chain_sel_i == DSC_CHAIN_SCC);
endmodule : dsc_top
`default_nettype wire

// ===== testbench/dsc_cache_model.sv
`default_nettype none
// Stand-in for the caches: answers tag lookups and flush requests
module dsc_cache_model
    import dsc_pkg::*;
#(
    parameter int FLUSH_DLY = 2000
)
(
    // Clock
    input wire logic mclk_i,
    // Tag lookup and answer
    input wire logic tag_rd_i,
    input wire logic tag_rd_data_i,
    input wire dsc_tag_addr_s tag_addr_i,
    input wire logic [7:0] ack_dly_i,
    output dsc_tag_entry_s tag_entry_o,
    output logic tag_ack_o,
    // Flush handshake
    input wire logic flush_req_i,
    output logic flush_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int ack_cnt = -1; // Cycles to the answer, -1 when idle
    int fl_cnt = 0; // Cycles the flush has been pending

    initial
    begin
        tag_entry_o = '0;
        tag_ack_o = 1'b0;
        flush_done_o = 1'b0;
    end

    // Answer after a chosen delay; dirty always set so the
    // device must mask it on the instruction side
    always @(posedge mclk_i)
    begin
        tag_ack_o <= 1'b0;
        // Entry bus toggles when not answering, no stale value
        tag_entry_o <= ~tag_entry_o;
        if (tag_rd_i)
            ack_cnt <= ack_dly_i;
        else if (ack_cnt > 0)
            ack_cnt <= ack_cnt - 1;
        else if (ack_cnt == 0)
        begin
            ack_cnt <= -1;
            tag_ack_o <= 1'b1;
            tag_entry_o <= {2'b11, tag_rd_data_i, 13'h0000, tag_addr_i};
        end
    end

    // Flush completes one pulse after a long pending time
    always @(posedge mclk_i)
    begin
        flush_done_o <= 1'b0;
        fl_cnt <= flush_req_i ? fl_cnt + 1 : 0;
        if (flush_req_i && fl_cnt == FLUSH_DLY)
            flush_done_o <= 1'b1;
    end
endmodule : dsc_cache_model
`default_nettype wire

// ===== testbench/test_debug_scan_cache_access.sv
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        total_checks++; \
        if ((got) !== (ex)) \
        begin \
            fail_count++; \
            $display("Error %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module test_debug_scan_cache_access
    import dsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Core side stimulus
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic dbg = 1'b1;
    logic cen = 1'b1;
    // Test port levels
    logic tck = 1'b0;
    logic tdi = 1'b0;
    logic shf = 1'b0;
    logic cap = 1'b0;
    logic upd = 1'b0;
    logic [4:0] chain = 5'h0F;
    logic tdo;
    // Cache side wires
    logic freq, fdone, trd, tdc, tack, ext;
    dsc_tag_addr_s taddr;
    dsc_tag_entry_s tent;
    logic [7:0] ack_dly = 8'h01;
    // Bookkeeping
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [38:0] rd;
    logic [31:0] w;
    logic [5:0] addrs [8] = '{6'h02, 6'h04, 6'h05, 6'h0A, 6'h12, 6'h1E,
        6'h21, 6'h3E};
    logic [6:0] idxs [2] = '{7'h00, 7'h3F};

    dsc_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck),
        .tdi_i(tdi), .shift_dr_i(shf), .capture_dr_i(cap),
        .update_dr_i(upd), .chain_sel_i(chain), .tdo_o(tdo),
        .debug_state_i(dbg), .cache_enable_i(cen),
        .instr_flush_req_o(freq), .instr_flush_done_i(fdone),
        .tag_rd_o(trd), .tag_rd_data_o(tdc), .tag_addr_o(taddr),
        .tag_entry_i(tent), .tag_ack_i(tack), .ext_mem_sel_o(ext));

    dsc_cache_model i_cache (.mclk_i(mclk_i), .tag_rd_i(trd),
        .tag_rd_data_i(tdc), .tag_addr_i(taddr), .ack_dly_i(ack_dly),
        .tag_entry_o(tent), .tag_ack_o(tack), .flush_req_i(freq),
        .flush_done_o(fdone));

    // Core clock, 200 MHz
    always #2.5 mclk_i = ~mclk_i;

    // Hang guard, well above the expected run length
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Counts and verdict, ends the run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Single test clock, levels change with the falling edge
    task automatic tck_pulse();
        #32 tck = 1'b1;
        #32 tck = 1'b0;
    endtask : tck_pulse

    // Capture, shift LSB first, update; tdo sampled just before rise
    task automatic scan(input logic [4:0] ch, input int n,
        input logic [38:0] din);
        @(posedge mclk_i);
        #1 chain = ch;
        rd = '0;
        cap = 1'b1;
        tck_pulse();
        cap = 1'b0;
        shf = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            tdi = din[i];
            #31 rd[i] = tdo;
            #1 tck = 1'b1;
            #32 tck = 1'b0;
        end
        shf = 1'b0;
        upd = 1'b1;
        tck_pulse();
        upd = 1'b0;
        // Room for the synchronisers and a slow lookup answer
        repeat (60) @(posedge mclk_i);
        #1;
    endtask : scan

    // Coprocessor write frame
    task automatic wr15(input logic [5:0] a, input logic [31:0] d);
        scan(DSC_CHAIN_SCC, DSC_SCC_LEN, {1'b1, a, d});
    endtask : wr15

    // Read takes two frames: address first, data captured next
    task automatic rd15(input logic [5:0] a);
        scan(DSC_CHAIN_SCC, DSC_SCC_LEN, {1'b0, a, 32'h0000_0000});
        scan(DSC_CHAIN_SCC, DSC_SCC_LEN, {1'b0, a, 32'h0000_0000});
        w = rd[31:0];
    endtask : rd15

    initial
    begin
        repeat (16) @(posedge mclk_i);
        #1 nrst_i = 1'b1;
        `CHK("flush idle", 1'b0, freq)
        `CHK("tag idle", 1'b0, trd)
        repeat (8) @(posedge mclk_i);
        // Save coprocessor state on entry, all still at reset value
        foreach (addrs[k])
        begin
            rd15(addrs[k]);
            `CHK("saved", DSC_WORD_RST, w)
        end
        // Distinct data per address exposes any aliasing in decode
        foreach (addrs[k])
            wr15(addrs[k], 32'hA5C3_0000 + k);
        foreach (addrs[k])
        begin
            rd15(addrs[k]);
            `CHK("reg", 32'hA5C3_0000 + k, w)
            `CHK("addr field", addrs[k], rd[37:32])
        end
        // Unmapped slots
        wr15(6'h03, 32'hFFFF_FFFF);
        rd15(6'h03);
        `CHK("unmapped", 32'h0000_0000, w)
        // Writes outside debug state leave the register alone
        dbg = 1'b0;
        wr15(6'h02, 32'h1234_5678);
        dbg = 1'b1;
        rd15(6'h02);
        `CHK("no debug", 32'hA5C3_0000, w)
        // Instruction cache flush and status polling
        wr15(6'h0F, 32'h0000_0000);
        `CHK("flush req", 1'b1, freq)
        rd15(6'h0F);
        `CHK("flush busy", 32'h8000_0000, w)
        for (int p = 0; p < 6 && w[DSC_FLUSH_BIT]; p++)
            rd15(6'h0F);
        `CHK("flush done", 32'h0000_0000, w)
        `CHK("flush req", 1'b0, freq)
        // Tag arrays, prompt answer on one, slow on the other
        for (int c = 0; c < 2; c++)
            foreach (idxs[j])
            begin
                ack_dly = c ? 8'h1E : 8'h01;
                scan(c ? DSC_CHAIN_DCTAG : DSC_CHAIN_ICTAG, DSC_TAG_LEN,
                    {10'h000, idxs[j], 16'h0000, 6'h05});
                `CHK("tag addr", {idxs[j], 6'h05}, taddr)
                `CHK("tag side", c[0], tdc)
                `CHK("cached load", 1'b0, ext)
                scan(c ? DSC_CHAIN_DCTAG : DSC_CHAIN_ICTAG, DSC_TAG_LEN,
                    {10'h000, idxs[j], 16'h0000, 6'h05});
                `CHK("tag out", {1'b1, c[0], c[0], 13'h0000, idxs[j],
                    6'h05}, rd[28:0])
            end
        // Uncached load marker follows the cache enable
        cen = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1 `CHK("ext mem", 1'b1, ext)
        cen = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 `CHK("ext mem", 1'b0, ext)
        tally_and_finish();
    end
endmodule : test_debug_scan_cache_access
`default_nettype wire
